// >>> hdl/aux_channel_defs.vh
// constants for the auxiliary sideband channel and its configuration store
// assumes one host clock of whole megahertz feeds all sideband logic
//
// Summary of operation
// - manchester-ii bits at fixed one megabit rate
// - all sideband sequencing runs on host clock
// - bit timing by integer division of clock
// - link-domain values pass synchronizer stages first
// - configuration registers read/write, host clock domain
// - single status bits returned without extra protection
// - lock bit freezes multi-bit status during read while attached
// - toggle bit signals reload of configuration copies
// - debug vector: rx, tx, enable_n, attach
// - lane symbol clock is link rate / 20
// - tolerate unstable lane clock when unplugged
`ifndef AUX_CHANNEL_DEFS_VH
`define AUX_CHANNEL_DEFS_VH

// timing
`define AUX_CLK_MHZ 200
`define AUX_BIT_NS 1000
`define AUX_NS_PER_US 1000

// configuration store layout
`define CFG_DEPTH 8
`define CFG_AW 3
`define CFG_DW 8
`define CFG_RESET_VAL 8'h00
`define CFG_RATE_IDX 0
`define CFG_RATE_LSB 0
`define CFG_RATE_W 2

// link rate selections and rates in Mbps
`define RATE_SEL_LOW 2'h0
`define RATE_SEL_MID 2'h1
`define RATE_SEL_HIGH 2'h2
`define RATE_LOW_MBPS 1620
`define RATE_MID_MBPS 2700
`define RATE_HIGH_MBPS 5400
`define LANE_DIVISOR 20

// debug vector positions
`define DBG_RX_BIT 0
`define DBG_TX_BIT 1
`define DBG_EN_N_BIT 2
`define DBG_ATTACH_BIT 3

`endif

// >>> hdl/cfg_store.v
// small register file holding link configuration bytes
// assumes writes and reads come from host-clock logic
`timescale 1ns/1ps
`include "aux_channel_defs.vh"

module cfg_store (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // access port
    input wire i_wr_en,
    input wire [`CFG_AW-1:0] i_addr,
    input wire [`CFG_DW-1:0] i_wdata,
    output reg [`CFG_DW-1:0] o_rdata,
    // whole contents for snapshot
    output wire [`CFG_DEPTH*`CFG_DW-1:0] o_flat
);
    reg [`CFG_DW-1:0] mem_r [0:`CFG_DEPTH-1];
    integer k;

    // storage and registered read, all on the host clock
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (k = 0; k < `CFG_DEPTH; k = k + 1) begin
                mem_r[k] <= `CFG_RESET_VAL;
            end
            o_rdata <= `CFG_RESET_VAL;
        end else begin
            if (i_wr_en) begin
                mem_r[i_addr] <= i_wdata;
            end
            o_rdata <= mem_r[i_addr];
        end
    end

    // flatten for the snapshot taken on reload
    genvar g;
    generate
        for (g = 0; g < `CFG_DEPTH; g = g + 1) begin : flat_g
            assign o_flat[g*`CFG_DW +: `CFG_DW] = mem_r[g];
        end
    endgenerate
endmodule // cfg_store

// >>> hdl/aux_channel.v
// auxiliary sideband channel: manchester transmit/receive, configuration
// store with toggle reload, locked status capture and a debug tap
// assumes i_clk is a whole number of MHz; line pins and link status are async
`timescale 1ns/1ps
`include "aux_channel_defs.vh"

module aux_channel (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // sideband line pin
    input wire i_aux_in,
    output reg o_aux_out,
    output reg o_aux_oe,
    // attach sense pin
    input wire i_attach_sense_pin,
    // transmit byte stream
    input wire i_tx_valid,
    input wire [7:0] i_tx_byte,
    input wire i_tx_last,
    output wire o_tx_ready,
    output wire o_tx_busy,
    // receive byte stream
    output reg [7:0] o_rx_byte,
    output reg o_rx_valid,
    output reg o_rx_end,
    output reg o_rx_err,
    // configuration access
    input wire i_cfg_wr_en,
    input wire [`CFG_AW-1:0] i_cfg_addr,
    input wire [`CFG_DW-1:0] i_cfg_wdata,
    output wire [`CFG_DW-1:0] o_cfg_rdata,
    input wire i_cfg_commit,
    output reg o_cfg_toggle,
    output reg [`CFG_DEPTH*`CFG_DW-1:0] o_cfg_snapshot,
    output reg [8:0] o_lane_clk_mhz,
    // link-domain status
    input wire i_link_locked,
    input wire [7:0] i_link_status,
    input wire i_status_lock,
    output wire o_link_locked,
    output reg [7:0] o_link_status,
    // debug tap
    output reg [3:0] o_aux_debug
);
    // bit timing from integer division of the host clock
    localparam integer BIT_CYC = (`AUX_BIT_NS * `AUX_CLK_MHZ) / `AUX_NS_PER_US;
    localparam integer BIT_LAST_I = BIT_CYC - 1;
    localparam integer HALF_I = BIT_CYC / 2;
    localparam integer QTR_I = BIT_CYC / 4;
    localparam integer TQTR_I = (BIT_CYC * 3) / 4;
    // counters are 8 bits, so one bit may span at most 256 host cycles
    localparam [7:0] BIT_LAST = BIT_LAST_I[7:0];
    localparam [7:0] HALF_CYC = HALF_I[7:0];
    localparam [7:0] QTR_CYC = QTR_I[7:0];
    localparam [7:0] TQTR_CYC = TQTR_I[7:0];

    // transmit states
    localparam TX_IDLE = 1'b0;
    localparam TX_SEND = 1'b1;
    // receive states
    localparam RX_IDLE = 1'b0;
    localparam RX_BIT = 1'b1;

    // lane symbol clock from the rate selection
    function [8:0] lane_mhz;
        input [`CFG_RATE_W-1:0] sel;
        reg [31:0] q;
        begin
            case (sel)
                `RATE_SEL_LOW: q = `RATE_LOW_MBPS / `LANE_DIVISOR;
                `RATE_SEL_MID: q = `RATE_MID_MBPS / `LANE_DIVISOR;
                `RATE_SEL_HIGH: q = `RATE_HIGH_MBPS / `LANE_DIVISOR;
                default: q = 32'h00000000;
            endcase
            lane_mhz = q[8:0]; // largest rate still fits nine bits
        end
    endfunction

    // three-stage synchronizers; a change counts once stages 2 and 3 agree
    reg [2:0] aux_sync_r;
    reg [2:0] att_sync_r;
    reg [2:0] lock_sync_r;
    reg [7:0] st_s1_r, st_s2_r, st_s3_r;
    reg aux_stable_r, att_stable_r, lock_stable_r;
    reg [7:0] st_stable_r;

    // everything below runs on the host clock only
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aux_sync_r <= 3'h7; // line idles high; a low start would fake an edge
            att_sync_r <= 3'h0;
            lock_sync_r <= 3'h0;
            st_s1_r <= 8'h00;
            st_s2_r <= 8'h00;
            st_s3_r <= 8'h00;
            aux_stable_r <= 1'b1;
            att_stable_r <= 1'b0;
            lock_stable_r <= 1'b0;
            st_stable_r <= 8'h00;
        end else begin
            aux_sync_r <= {aux_sync_r[1:0], i_aux_in};
            att_sync_r <= {att_sync_r[1:0], i_attach_sense_pin};
            lock_sync_r <= {lock_sync_r[1:0], i_link_locked};
            st_s1_r <= i_link_status;
            st_s2_r <= st_s1_r;
            st_s3_r <= st_s2_r;
            if (aux_sync_r[1] == aux_sync_r[2]) begin
                aux_stable_r <= aux_sync_r[2];
            end
            if (att_sync_r[1] == att_sync_r[2]) begin
                att_stable_r <= att_sync_r[2];
            end
            if (lock_sync_r[1] == lock_sync_r[2]) begin
                lock_stable_r <= lock_sync_r[2];
            end
            if (st_s2_r == st_s3_r) begin
                st_stable_r <= st_s3_r; // only whole agreeing words pass
            end
        end
    end

    // single bit passes unguarded: old or new value are both valid
    assign o_link_locked = lock_stable_r & att_stable_r;

    // status word frozen while attached and the host holds the lock bit
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_link_status <= 8'h00;
        end else if (!att_stable_r) begin
            o_link_status <= 8'h00; // recovered clock is junk when unplugged
        end else if (!i_status_lock) begin
            o_link_status <= st_stable_r;
        end
    end

    // configuration store
    wire [`CFG_DEPTH*`CFG_DW-1:0] cfg_flat;

    cfg_store u_cfg (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_wr_en(i_cfg_wr_en),
        .i_addr(i_cfg_addr),
        .i_wdata(i_cfg_wdata),
        .o_rdata(o_cfg_rdata),
        .o_flat(cfg_flat)
    );

    // reload: snapshot and toggle move together so the far side sees a
    // coherent set after syncing the toggle
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_toggle <= 1'b0;
            o_cfg_snapshot <= {`CFG_DEPTH{`CFG_RESET_VAL}};
            o_lane_clk_mhz <= 9'h000;
        end else if (i_cfg_commit) begin
            o_cfg_toggle <= ~o_cfg_toggle;
            o_cfg_snapshot <= cfg_flat;
            o_lane_clk_mhz <= lane_mhz(cfg_flat[`CFG_RATE_IDX*`CFG_DW+`CFG_RATE_LSB +: `CFG_RATE_W]);
        end
    end

    // transmitter
    reg tx_st_r;
    reg [7:0] tx_cnt_r;
    reg [7:0] tx_shift_r;
    reg [2:0] tx_bit_r;
    reg tx_last_r;
    reg rx_st_r;
    wire tx_byte_end = (tx_st_r == TX_SEND) && (tx_cnt_r == BIT_LAST) && (tx_bit_r == 3'h7);
    wire tx_take;

    // half duplex: no new frame while a reply is coming in
    assign o_tx_ready = ((tx_st_r == TX_IDLE) && (rx_st_r == RX_IDLE)) || (tx_byte_end && !tx_last_r);
    assign tx_take = o_tx_ready && i_tx_valid;
    assign o_tx_busy = (tx_st_r == TX_SEND);

    // manchester-ii: first half carries the bit, second half its inverse
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_st_r <= TX_IDLE;
            tx_cnt_r <= 8'h00;
            tx_shift_r <= 8'h00;
            tx_bit_r <= 3'h0;
            tx_last_r <= 1'b0;
            o_aux_out <= 1'b0;
            o_aux_oe <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    o_aux_oe <= 1'b0;
                    o_aux_out <= 1'b0;
                    if (tx_take) begin
                        tx_st_r <= TX_SEND;
                        tx_shift_r <= i_tx_byte;
                        tx_last_r <= i_tx_last;
                        tx_cnt_r <= 8'h00;
                        tx_bit_r <= 3'h0;
                        o_aux_oe <= 1'b1;
                        o_aux_out <= i_tx_byte[7]; // msb first
                    end
                end
                TX_SEND: begin
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_cnt_r <= 8'h00;
                        if (tx_bit_r == 3'h7) begin
                            if (tx_take) begin
                                tx_shift_r <= i_tx_byte;
                                tx_last_r <= i_tx_last;
                                tx_bit_r <= 3'h0;
                                o_aux_out <= i_tx_byte[7];
                            end else begin
                                tx_st_r <= TX_IDLE; // last byte or underrun ends frame
                                o_aux_oe <= 1'b0;
                                o_aux_out <= 1'b0;
                            end
                        end else begin
                            tx_bit_r <= tx_bit_r + 3'h1;
                            tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                            o_aux_out <= tx_shift_r[6];
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r + 8'h01;
                        if (tx_cnt_r == HALF_CYC - 8'h01) begin
                            o_aux_out <= ~tx_shift_r[7]; // mid-bit transition
                        end
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                    o_aux_oe <= 1'b0;
                end
            endcase
        end
    end

    // receiver: samples each half at its centre, resyncs on mid-bit edge
    reg [7:0] rx_cnt_r;
    reg [2:0] rx_bit_r;
    reg [7:0] rx_shift_r;
    reg rx_h1_r;
    reg rx_prev_r;
    reg rx_seen_r;
    wire rx_edge = (aux_stable_r != rx_prev_r);

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= 8'h00;
            rx_bit_r <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_h1_r <= 1'b0;
            rx_prev_r <= 1'b1; // matches idle line, no false start after reset
            rx_seen_r <= 1'b0;
            o_rx_byte <= 8'h00;
            o_rx_valid <= 1'b0;
            o_rx_end <= 1'b0;
            o_rx_err <= 1'b0;
        end else begin
            rx_prev_r <= aux_stable_r;
            o_rx_valid <= 1'b0;
            o_rx_end <= 1'b0;
            o_rx_err <= 1'b0;
            case (rx_st_r)
                RX_IDLE: begin
                    // first edge while not driving marks a bit boundary
                    if (rx_edge && (tx_st_r == TX_IDLE) && !o_aux_oe) begin
                        rx_st_r <= RX_BIT;
                        rx_cnt_r <= 8'h01;
                        rx_bit_r <= 3'h0;
                        rx_seen_r <= 1'b0;
                    end
                end
                RX_BIT: begin
                    if (rx_edge && (rx_cnt_r > QTR_CYC) && (rx_cnt_r < TQTR_CYC) && !rx_seen_r) begin
                        rx_cnt_r <= HALF_CYC + 8'h01; // track source drift
                        rx_seen_r <= 1'b1;
                    end else if (rx_cnt_r == BIT_LAST) begin
                        rx_cnt_r <= 8'h00;
                        rx_seen_r <= 1'b0;
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 8'h01;
                    end
                    if (rx_cnt_r == QTR_CYC) begin
                        rx_h1_r <= aux_stable_r;
                    end
                    if (rx_cnt_r == TQTR_CYC) begin
                        if (aux_stable_r == rx_h1_r) begin
                            // no mid transition: idle line or stop, frame over
                            rx_st_r <= RX_IDLE;
                            o_rx_end <= 1'b1;
                            o_rx_err <= (rx_bit_r != 3'h0);
                        end else begin
                            rx_shift_r <= {rx_shift_r[6:0], rx_h1_r};
                            rx_bit_r <= rx_bit_r + 3'h1;
                            if (rx_bit_r == 3'h7) begin
                                o_rx_byte <= {rx_shift_r[6:0], rx_h1_r};
                                o_rx_valid <= 1'b1;
                            end
                        end
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // debug tap of the line state
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_aux_debug <= 4'h4;
        end else begin
            o_aux_debug[`DBG_RX_BIT] <= aux_stable_r;
            o_aux_debug[`DBG_TX_BIT] <= o_aux_out;
            o_aux_debug[`DBG_EN_N_BIT] <= ~o_aux_oe;
            o_aux_debug[`DBG_ATTACH_BIT] <= att_stable_r;
        end
    end
endmodule // aux_channel

// >>> test/aux_source_model.sv
// source-side model driving manchester frames onto the sideband line
// assumes the bench host clock; drives only at falling edges
`timescale 1ns/1ps
module aux_source_model (
    // clock
    input wire logic i_clk,
    // line toward the receiver
    output logic o_line
);
    initial o_line = 1'b1;
    // msb first, value half then inverse half, 100 cycles each
    task automatic send(input logic [15:0] d, input int n);
        int i;
        int c;
        for (i = n - 1; i >= 0; i--) begin
            for (c = 0; c < 200; c++) begin
                @(negedge i_clk);
                o_line = (c < 100) ? d[i] : !d[i];
            end
        end
        // released line flips rather than keeping its old level
        @(negedge i_clk);
        o_line = d[0];
    endtask
endmodule // aux_source_model

// >>> test/aux_channel_asserts.sv
// checker for line timing, debug tap, config reload and status paths
// assumes binding into aux_channel; single host clock domain
`timescale 1ns/1ps
module aux_channel_asserts (
    // clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // line and debug
    input wire o_aux_out,
    input wire o_aux_oe,
    input wire i_attach_sense_pin,
    input wire [3:0] o_aux_debug,
    // configuration
    input wire i_cfg_commit,
    input wire o_cfg_toggle,
    input wire [63:0] o_cfg_snapshot,
    input wire [8:0] o_lane_clk_mhz,
    // status
    input wire [7:0] i_link_status,
    input wire i_status_lock,
    input wire [7:0] o_link_status
);
    reg [7:0] run_r;
    reg [15:0] oe_len_r;
    reg out_q_r;
    // level run length and drive window length, too long to unroll
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_r <= 8'h00;
            oe_len_r <= 16'h0000;
            out_q_r <= 1'b0;
        end else begin
            out_q_r <= o_aux_out;
            run_r <= !o_aux_oe ? 8'h00 : (o_aux_out != out_q_r) ? 8'h01 : run_r + 8'h01;
            oe_len_r <= o_aux_oe ? oe_len_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_mid_bit;
        o_aux_oe && out_q_r != o_aux_out && run_r != 8'h00 |-> run_r == 8'h64 || run_r == 8'hC8;
    endproperty
    a_mid_bit: assert property (p_mid_bit) else $error("line edge off the half-bit grid");
    property p_frame_len;
        $fell(o_aux_oe) |-> oe_len_r % 16'h0640 == 16'h0000;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("drive window not whole bytes");
    property p_dbg_attach;
        $stable(i_attach_sense_pin)[*8] |-> o_aux_debug[3] == i_attach_sense_pin;
    endproperty
    a_dbg_attach: assert property (p_dbg_attach) else $error("debug attach bit wrong");
    property p_dbg_en;
        $stable(o_aux_oe)[*3] |-> o_aux_debug[2] == !o_aux_oe;
    endproperty
    a_dbg_en: assert property (p_dbg_en) else $error("debug enable bit wrong");
    property p_toggle;
        i_cfg_commit |=> o_cfg_toggle != $past(o_cfg_toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not flip");
    property p_hold;
        !i_cfg_commit |=> $stable(o_cfg_toggle) && $stable(o_cfg_snapshot) && $stable(o_lane_clk_mhz);
    endproperty
    a_hold: assert property (p_hold) else $error("copies moved without commit");
    property p_lane;
        o_lane_clk_mhz inside {9'h000, 9'h051, 9'h087, 9'h10E};
    endproperty
    a_lane: assert property (p_lane) else $error("lane clock value illegal");
    property p_lock;
        i_status_lock[*4] |-> $stable(o_link_status);
    endproperty
    a_lock: assert property (p_lock) else $error("status moved while locked");
    property p_pass;
        ($stable(i_link_status) && !i_status_lock && i_attach_sense_pin)[*8] |-> o_link_status == i_link_status;
    endproperty
    a_pass: assert property (p_pass) else $error("status not passed through");
endmodule // aux_channel_asserts

// >>> test/tb.sv
// bench for the sideband channel: tx, rx, config store, status
// assumes the model drives the line and the checker is bound below
`timescale 1ns/1ps
module tb;
    logic i_clk, i_reset_n, i_aux_in, i_attach_sense_pin, i_tx_valid, i_tx_last;
    logic i_cfg_wr_en, i_cfg_commit, i_link_locked, i_status_lock;
    logic [7:0] i_tx_byte, i_cfg_wdata, i_link_status, o_rx_byte, o_cfg_rdata, o_link_status;
    logic [2:0] i_cfg_addr;
    logic o_aux_out, o_aux_oe, o_tx_ready, o_tx_busy, o_rx_valid, o_rx_end, o_rx_err;
    logic o_cfg_toggle, o_link_locked;
    logic [63:0] o_cfg_snapshot;
    logic [8:0] o_lane_clk_mhz;
    logic [3:0] o_aux_debug;
    int failures = 0;
    int compares = 0;
    aux_channel uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_aux_in(i_aux_in), .o_aux_out(o_aux_out), .o_aux_oe(o_aux_oe),
        .i_attach_sense_pin(i_attach_sense_pin), .i_tx_valid(i_tx_valid), .i_tx_byte(i_tx_byte),
        .i_tx_last(i_tx_last), .o_tx_ready(o_tx_ready), .o_tx_busy(o_tx_busy), .o_rx_byte(o_rx_byte),
        .o_rx_valid(o_rx_valid), .o_rx_end(o_rx_end), .o_rx_err(o_rx_err), .i_cfg_wr_en(i_cfg_wr_en),
        .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_cfg_commit(i_cfg_commit),
        .o_cfg_toggle(o_cfg_toggle), .o_cfg_snapshot(o_cfg_snapshot), .o_lane_clk_mhz(o_lane_clk_mhz),
        .i_link_locked(i_link_locked), .i_link_status(i_link_status), .i_status_lock(i_status_lock),
        .o_link_locked(o_link_locked), .o_link_status(o_link_status), .o_aux_debug(o_aux_debug)
    );
    aux_source_model src (.i_clk(i_clk), .o_line(i_aux_in));
    // 200 MHz host clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_reset;
        check(o_aux_debug, 4'h4);
        check(o_aux_oe, 1'b0);
        check(o_tx_ready, 1'b1);
    endtask
    // fill the store, read back, then commit every rate selection
    task automatic t_cfg;
        int k;
        logic [8:0] lane [4] = '{9'h051, 9'h087, 9'h10E, 9'h000};
        for (k = 0; k < 8; k++) begin
            i_cfg_wr_en = 1'b1;
            i_cfg_addr = k[2:0];
            i_cfg_wdata = 8'hA0 + k[7:0];
            cyc(1);
        end
        i_cfg_wr_en = 1'b0;
        for (k = 0; k < 8; k++) begin
            i_cfg_addr = k[2:0];
            cyc(2);
            check(o_cfg_rdata, 8'hA0 + k[7:0]);
        end
        for (k = 0; k < 4; k++) begin
            i_cfg_wr_en = 1'b1;
            i_cfg_addr = 3'h0;
            i_cfg_wdata = 8'hA0 | k[7:0];
            cyc(1);
            i_cfg_wr_en = 1'b0;
            i_cfg_commit = 1'b1;
            cyc(1);
            i_cfg_commit = 1'b0;
            check(o_cfg_toggle, !k[0]);
            check(o_cfg_snapshot, 64'hA7A6A5A4A3A2A1A0 | k);
            check(o_lane_clk_mhz, lane[k]);
        end
    endtask
    // two bytes back to back, each half of every bit sampled mid-way
    task automatic t_tx;
        logic [15:0] d = 16'hA53C;
        int i;
        i_tx_valid = 1'b1;
        i_tx_byte = 8'hA5;
        while (!o_tx_ready) cyc(1);
        @(posedge i_clk);
        fork
            for (i = 15; i >= 0; i--) begin
                cyc(50);
                check(o_aux_out, d[i]);
                check(o_aux_debug[1], d[i]);
                cyc(100);
                check(o_aux_out, !d[i]);
                cyc(50);
            end
            begin
                cyc(1);
                i_tx_byte = 8'h3C;
                i_tx_last = 1'b1;
                while (!o_tx_ready) cyc(1);
                cyc(1);
                i_tx_valid = 1'b0;
            end
        join
        cyc(2);
        check(o_aux_oe, 1'b0);
        check(o_tx_busy, 1'b0);
    endtask
    // one frame from the source, bytes collected until frame end
    task automatic rx_frame(input logic [15:0] d, input int n, input int nb, input logic err);
        logic [7:0] got [$];
        int c;
        fork
            src.send(d, n);
            // always step first: the previous frame's end pulse may still stand
            for (c = 0; c < 4500; c++) begin
                cyc(1);
                if (o_rx_valid === 1'b1) got.push_back(o_rx_byte);
                if (o_rx_end === 1'b1) break;
            end
        join
        check(o_rx_end, 1'b1);
        check(o_rx_err, err);
        check(got.size(), nb);
        check(o_aux_debug[0], d[0]);
        if (nb == 2) begin
            check(got[0], d[15:8]);
            check(got[1], d[7:0]);
        end
    endtask
    task automatic t_rx;
        rx_frame(16'h5AC3, 16, 2, 1'b0);
        rx_frame(16'h0005, 4, 0, 1'b1);
    endtask
    // status sync, lock freeze and detach clearing
    task automatic t_status;
        i_link_status = 8'h96;
        i_link_locked = 1'b1;
        cyc(8);
        check(o_link_status, 8'h96);
        check(o_link_locked, 1'b1);
        i_status_lock = 1'b1;
        cyc(4);
        i_link_status = 8'h69;
        cyc(8);
        check(o_link_status, 8'h96);
        i_status_lock = 1'b0;
        i_link_locked = 1'b0;
        cyc(8);
        check(o_link_status, 8'h69);
        check(o_link_locked, 1'b0);
        i_attach_sense_pin = 1'b0;
        i_link_locked = 1'b1;
        cyc(8);
        check(o_link_status, 8'h00);
        check(o_link_locked, 1'b0);
        check(o_aux_debug[3], 1'b0);
    endtask
    // main sequence
    initial begin
        {i_reset_n, i_tx_valid, i_tx_last, i_cfg_wr_en, i_cfg_commit, i_link_locked, i_status_lock} = 7'h00;
        {i_tx_byte, i_cfg_wdata, i_link_status, i_cfg_addr} = 27'h0;
        i_attach_sense_pin = 1'b1;
        cyc(5);
        t_reset;
        i_reset_n = 1'b1;
        cyc(8);
        t_cfg;
        t_tx;
        t_rx;
        t_status;
        stop_test;
    end
    // watchdog well past the expected run length
    initial begin
        #200000;
        failures++;
        stop_test;
    end
endmodule // tb
bind aux_channel aux_channel_asserts chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .o_aux_out(o_aux_out), .o_aux_oe(o_aux_oe),
    .i_attach_sense_pin(i_attach_sense_pin), .o_aux_debug(o_aux_debug), .i_cfg_commit(i_cfg_commit),
    .o_cfg_toggle(o_cfg_toggle), .o_cfg_snapshot(o_cfg_snapshot), .o_lane_clk_mhz(o_lane_clk_mhz),
    .i_link_status(i_link_status), .i_status_lock(i_status_lock), .o_link_status(o_link_status)
);
